// ==== fzd_datapath.sv ====
// fuzzy inference datapath: fuzzify, stack, min/max, accumulate, defuzzify
`timescale 1ns/1ns
`default_nettype none
`include "fzd_map.svh"
module fzd_datapath #(
   parameter int DW = 8,
   parameter int AW = 8,
   parameter int ACCW = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // instruction from the sequencer
   input wire logic opValid,
   input wire fzd_pkg::fzd_op_t opCode,
   input wire logic [DW-1:0] inputValue,
   input wire logic [AW-1:0] mfAddr,
   input wire logic [DW-1:0] conConst,
   input wire logic [AW-1:0] outDest,
   output logic opReady,
   // program memory port for membership data
   output logic progRead,
   output logic [AW-1:0] progAddr,
   input wire logic [DW-1:0] progData,
   // data memory write port
   output logic memWrite,
   output logic [AW-1:0] memAddr,
   output logic [DW-1:0] memData,
   // visible state
   output logic [3:0] lastResult,
   output logic [3:0] heldResult,
   output logic [3:0] stack0,
   output logic [3:0] stack1
);
   import fzd_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_LEFT, S_VERTEX, S_RIGHT, S_GRADE, S_DIV, S_WAIT} fzd_state_t;
   fzd_state_t state;
   logic negate;
   logic [DW-1:0] xIn;
   logic [DW-1:0] leftW;
   logic [DW-1:0] vertex;
   logic [AW-1:0] mfBase;
   logic [AW-1:0] dest;
   logic [ACCW-1:0] dividendAcc;
   logic [ACCW-1:0] divisorAcc;
   logic divStart;
   logic divDone;
   logic [DW-1:0] quotient;
   logic [3:0] alpha;
   logic pushEn;
   logic [3:0] pushVal;

   // triangular grade: scale distance from vertex against half-base
   function automatic logic [3:0] tri_grade(input logic [DW-1:0] d, input logic [DW-1:0] w);
      logic [DW+3:0] num;
      logic [DW+3:0] q;
      num = '0;
      q = '0;
      if (w == '0 || d >= w) begin
         tri_grade = `FZD_ALPHA_ZERO;
      end else begin
         num = {4'h0, w - d} * (DW+4)'(`FZD_ALPHA_MAX);
         q = num / {4'h0, w};
         tri_grade = q[3:0];
      end
   endfunction

   assign opReady = (state == S_IDLE);

   ////////////////////////////////////////////////////////////
   // fetch sequence and output sequence
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state <= S_IDLE;
         negate <= 1'b0;
         xIn <= '0;
         leftW <= '0;
         vertex <= '0;
         mfBase <= '0;
         dest <= '0;
      end else begin
         case (state)
            S_IDLE: begin
               if (opValid && (opCode == FZD_OP_PUSH_GRADE || opCode == FZD_OP_PUSH_NEGATED_GRADE)) begin
                  negate <= (opCode == FZD_OP_PUSH_NEGATED_GRADE);
                  xIn <= inputValue;
                  mfBase <= mfAddr;
                  state <= S_LEFT;
               end else if (opValid && opCode == FZD_OP_OUT) begin
                  dest <= outDest;
                  state <= S_DIV;
               end
            end
            S_LEFT: state <= S_VERTEX;
            S_VERTEX: begin
               leftW <= progData;
               state <= S_RIGHT;
            end
            S_RIGHT: begin
               vertex <= progData;
               state <= S_GRADE;
            end
            S_GRADE: state <= S_IDLE;
            S_DIV: state <= S_WAIT;
            S_WAIT: if (divDone) state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // membership data: left half-base, vertex, right half-base in order
   assign progRead = (state == S_LEFT) || (state == S_VERTEX) || (state == S_RIGHT);
   assign progAddr = (state == S_VERTEX) ? mfBase + AW'(`FZD_MF_VERTEX) :
                     (state == S_RIGHT) ? mfBase + AW'(`FZD_MF_RIGHT) : mfBase + AW'(`FZD_MF_LEFT);

   // right half-base arrives in S_GRADE
   always_comb begin
      if (xIn <= vertex) alpha = tri_grade(vertex - xIn, leftW);
      else alpha = tri_grade(xIn - vertex, progData);
   end

   ////////////////////////////////////////////////////////////
   // push source selection
   always_comb begin
      pushEn = 1'b0;
      pushVal = `FZD_ALPHA_ZERO;
      if (state == S_GRADE) begin
         pushEn = 1'b1;
         pushVal = negate ? `FZD_ALPHA_MAX - alpha : alpha;
      end else if (state == S_IDLE && opValid && opCode == FZD_OP_PUSH_LAST) begin
         pushEn = 1'b1;
         pushVal = lastResult;
      end else if (state == S_IDLE && opValid && opCode == FZD_OP_PUSH_HELD_RESULT) begin
         pushEn = 1'b1;
         pushVal = heldResult;
      end
   end

   // two-entry fuzzy stack
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         stack0 <= `FZD_ALPHA_ZERO;
         stack1 <= `FZD_ALPHA_ZERO;
      end else if (pushEn) begin
         stack0 <= pushVal;
         stack1 <= stack0;
      end
   end

   ////////////////////////////////////////////////////////////
   // min/max into last result, store into held result
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         lastResult <= `FZD_ALPHA_ZERO;
         heldResult <= `FZD_ALPHA_ZERO;
      end else if (state == S_IDLE && opValid) begin
         case (opCode)
            FZD_OP_AND: lastResult <= (stack0 < stack1) ? stack0 : stack1;
            FZD_OP_OR: lastResult <= (stack0 > stack1) ? stack0 : stack1;
            FZD_OP_STORE: heldResult <= lastResult;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // accumulators; cleared when the divider reports done, on the same edge that raises memWrite
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         dividendAcc <= '0;
         divisorAcc <= '0;
      end else if (state == S_WAIT && divDone) begin
         dividendAcc <= '0;
         divisorAcc <= '0;
      end else if (state == S_IDLE && opValid && opCode == FZD_OP_CON) begin
         // wraps silently if too many rules fire; width sized by ACCW
         dividendAcc <= dividendAcc + ACCW'({4'h0, conConst} * {{DW{1'b0}}, lastResult});
         divisorAcc <= divisorAcc + ACCW'(lastResult);
      end
   end

   assign divStart = (state == S_DIV);

   fzd_divider #(.NW(ACCW), .QW(DW)) uDiv (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start(divStart),
      .dividend(dividendAcc),
      .divisor(divisorAcc),
      .done(divDone),
      .quotient(quotient)
   );

   ////////////////////////////////////////////////////////////
   // data memory write of the crisp result
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         memWrite <= 1'b0;
         memAddr <= '0;
         memData <= '0;
      end else begin
         memWrite <= (state == S_WAIT) && divDone;
         if (state == S_WAIT && divDone) begin
            memAddr <= dest;
            memData <= quotient;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // checks
   a_and_min: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_AND) |=> lastResult == ($past(stack0) < $past(stack1) ? $past(stack0) : $past(stack1)))
      else $error("and result is not the minimum");
   a_or_max: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_OR) |=> lastResult == ($past(stack0) > $past(stack1) ? $past(stack0) : $past(stack1)))
      else $error("or result is not the maximum");
   a_store_held: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_STORE) |=> heldResult == $past(lastResult) && $stable(lastResult))
      else $error("store did not copy last result");
   a_push_last: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_PUSH_LAST) |=> stack0 == $past(lastResult) && stack1 == $past(stack0))
      else $error("push last result wrong");
   a_push_held: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_PUSH_HELD_RESULT) |=> stack0 == $past(heldResult))
      else $error("push held result wrong");
   a_con_divisor: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_CON) |=> divisorAcc == $past(divisorAcc) + ACCW'($past(lastResult)))
      else $error("divisor not accumulated");
   a_con_dividend: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_CON) |=>
      dividendAcc == $past(dividendAcc) + ACCW'($past(conConst)) * ACCW'($past(lastResult)))
      else $error("dividend not accumulated");
   a_grade_push: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_PUSH_GRADE) |-> ##5 stack1 == $past(stack0, 5))
      else $error("grade not pushed after fetch");
   a_out_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (opReady && opValid && opCode == FZD_OP_OUT) |-> ##[3:40] memWrite)
      else $error("output never written");
   a_acc_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
      memWrite |-> divisorAcc == '0 && dividendAcc == '0)
      else $error("accumulators not cleared");
endmodule
`default_nettype wire

// ==== fzd_datapath_bench.sv ====
// self-checking bench of the fuzzy inference datapath
`timescale 1ns/1ns
`default_nettype none
module fzd_datapath_bench;
   import fzd_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic opValid = 1'b0;
   fzd_op_t opCode = FZD_OP_NONE;
   logic [7:0] inputValue = 8'h00, mfAddr = 8'h00, conConst = 8'h00, outDest = 8'h00;
   logic opReady, progRead, memWrite;
   logic [7:0] progAddr, progData, memAddr, memData;
   logic [3:0] lastResult, heldResult, stack0, stack1;
   logic [3:0] e0 = 4'h0, e1 = 4'h0, eK = 4'h0, eM = 4'h0;
   logic [19:0] dvd = 20'h00000, dvs = 20'h00000;
   logic [31:0] seed = 32'h0000003f;
   int miscompares = 0, compares = 0;
   ////////////////////////////////////////
   // clock of 100 ns period
   always #50 sys_clk = ~sys_clk;
   fzd_datapath u_fzd_datapath (.sys_clk(sys_clk), .reset_n(reset_n), .opValid(opValid), .opCode(opCode),
      .inputValue(inputValue), .mfAddr(mfAddr), .conConst(conConst), .outDest(outDest), .opReady(opReady),
      .progRead(progRead), .progAddr(progAddr), .progData(progData), .memWrite(memWrite), .memAddr(memAddr),
      .memData(memData), .lastResult(lastResult), .heldResult(heldResult), .stack0(stack0), .stack1(stack1));
   fzd_mem_model u_fzd_mem_model (.sys_clk(sys_clk), .progRead(progRead), .progAddr(progAddr),
      .progData(progData), .memWrite(memWrite), .memAddr(memAddr), .memData(memData));
   ////////////////////////////////////////
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // triangular grade, the side picked by where the input lies
   function automatic logic [3:0] grade(input logic [7:0] iv, l, v, r);
      logic [7:0] d, w;
      d = (iv < v) ? v - iv : iv - v;
      w = (iv < v) ? l : r;
      if (w == 8'h00 || d >= w) return 4'h0;
      return 4'((12'(w - d) * 12'h00f) / 12'(w));
   endfunction
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (!ok) begin
         miscompares++;
         $display("BAD at %0t: %s", $time, msg);
      end
   endtask
   // one bounded cycle of waiting; a hang ends the run
   task automatic step(inout int n);
      @(negedge sys_clk);
      n++;
      if (n > 60) begin
         miscompares++;
         $display("BAD at %0t: no progress", $time);
         report_and_stop();
      end
   endtask
   // checks the state left by the previous op, then issues one op
   task automatic do_op(input fzd_op_t op, input logic [7:0] iv, cc, l, v, r);
      logic [7:0] a, d, q;
      logic [3:0] g;
      int n;
      n = 0;
      @(negedge sys_clk);
      while (opReady !== 1'b1) begin
         step(n);
      end
      chk(stack0 === e0 && stack1 === e1, "stack contents");
      chk(lastResult === eK, "last result");
      chk(heldResult === eM, "held result");
      seed = xorshift(seed);
      a = {seed[7:2], 2'b00};
      d = seed[15:8];
      u_fzd_mem_model.pmem[a] = l;
      u_fzd_mem_model.pmem[a + 8'h01] = v;
      u_fzd_mem_model.pmem[a + 8'h02] = r;
      opValid = 1'b1;
      opCode = op;
      inputValue = iv;
      mfAddr = a;
      conConst = cc;
      outDest = d;
      @(negedge sys_clk);
      opValid = 1'b0;
      g = grade(iv, l, v, r);
      case (op)
         FZD_OP_PUSH_GRADE: {e1, e0} = {e0, g};
         FZD_OP_PUSH_NEGATED_GRADE: {e1, e0} = {e0, 4'hf - g};
         FZD_OP_PUSH_LAST: {e1, e0} = {e0, eK};
         FZD_OP_PUSH_HELD_RESULT: {e1, e0} = {e0, eM};
         FZD_OP_AND: eK = (e0 < e1) ? e0 : e1;
         FZD_OP_OR: eK = (e0 > e1) ? e0 : e1;
         FZD_OP_STORE: eM = eK;
         FZD_OP_CON: begin
            dvd = dvd + 20'(eK) * 20'(cc);
            dvs = dvs + 20'(eK);
         end
         FZD_OP_OUT: begin
            q = (dvs == 20'h00000) ? 8'h00 : (dvd / dvs > 20'h000ff) ? 8'hff : 8'(dvd / dvs);
            do begin
               step(n);
            end while (memWrite !== 1'b1);
            chk(memAddr === d && memData === q, "defuzzified output");
            @(negedge sys_clk);
            chk(memWrite === 1'b0 && u_fzd_mem_model.dmem[d] === q, "memory write");
            dvd = 20'h00000;
            dvs = 20'h00000;
         end
         default: ;
      endcase
   endtask
   ////////////////////////////////////////
   // reset held four cycles, corner cases by hand, then a seeded random run
   initial begin
      repeat (4) @(negedge sys_clk);
      reset_n = 1'b1;
      do_op(FZD_OP_PUSH_GRADE, 8'h40, 8'h00, 8'h10, 8'h40, 8'h20);
      do_op(FZD_OP_PUSH_NEGATED_GRADE, 8'h50, 8'h00, 8'h10, 8'h40, 8'h20);
      do_op(FZD_OP_AND, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      do_op(FZD_OP_STORE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      do_op(FZD_OP_OR, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      do_op(FZD_OP_PUSH_HELD_RESULT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      do_op(FZD_OP_PUSH_GRADE, 8'h38, 8'h00, 8'h10, 8'h40, 8'h20);
      do_op(FZD_OP_PUSH_GRADE, 8'hf0, 8'h00, 8'h10, 8'h40, 8'h20);
      do_op(FZD_OP_PUSH_LAST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      do_op(FZD_OP_CON, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00);
      do_op(FZD_OP_CON, 8'h00, 8'hc8, 8'h00, 8'h00, 8'h00);
      do_op(FZD_OP_OUT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      do_op(FZD_OP_OUT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      $display("corner cases done");
      // wide half-bases keep most random inputs inside the triangle
      for (int i = 0; i < 120; i++) begin
         seed = xorshift(seed);
         do_op(fzd_op_t'(4'(seed[31:16] % 16'd10)), seed[7:0], seed[15:8], {1'b1, seed[22:16]},
            seed[29:22], {1'b1, seed[30:24]});
      end
      do_op(FZD_OP_NONE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      $display("random run done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== fzd_divider.sv ====
// sequential restoring divider used for defuzzification
`timescale 1ns/1ns
`default_nettype none
module fzd_divider #(
   parameter int NW = 20,
   parameter int QW = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // request
   input wire logic start,
   input wire logic [NW-1:0] dividend,
   input wire logic [NW-1:0] divisor,
   // answer
   output logic done,
   output logic [QW-1:0] quotient
);
   logic [NW-1:0] rem;
   logic [NW-1:0] quo;
   logic [NW-1:0] den;
   logic [$clog2(NW+1)-1:0] cnt;
   logic busy;
   logic [NW:0] trial;
   localparam int CW = $clog2(NW+1);

   // shift one dividend bit into the remainder, then try the subtraction; a set top bit means it went negative
   assign trial = {rem, quo[NW-1]} - {1'b0, den};

   ////////////////////////////////////////////////////////////
   // one quotient bit per clock; zero divisor gives zero
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rem <= '0;
         quo <= '0;
         den <= '0;
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         quotient <= '0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            rem <= '0;
            quo <= dividend;
            den <= divisor;
            cnt <= CW'(NW);
            busy <= 1'b1;
         end else if (busy) begin
            if (cnt == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
               // saturate: quotient never exceeds output range for valid data
               quotient <= (den == '0) ? '0 : (|quo[NW-1:QW] ? '1 : quo[QW-1:0]);
            end else begin
               cnt <= cnt - 1'b1;
               if (!trial[NW]) begin
                  rem <= trial[NW-1:0];
                  quo <= {quo[NW-2:0], 1'b1};
               end else begin
                  rem <= {rem[NW-2:0], quo[NW-1]};
                  quo <= {quo[NW-2:0], 1'b0};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== fzd_map.svh ====
// grade and membership-offset constants of the fuzzy inference datapath
`ifndef FZD_MAP_SVH
`define FZD_MAP_SVH
`define FZD_ALPHA_MAX 4'hf
`define FZD_ALPHA_ZERO 4'h0
`define FZD_MF_LEFT 2'h0
`define FZD_MF_VERTEX 2'h1
`define FZD_MF_RIGHT 2'h2
`endif

// ==== fzd_mem_model.sv ====
// program and data memory model facing the fuzzy datapath
`timescale 1ns/1ns
`default_nettype none
module fzd_mem_model (
   // clock
   input wire logic sys_clk,
   // membership data port
   input wire logic progRead,
   input wire logic [7:0] progAddr,
   output logic [7:0] progData,
   // data memory write port
   input wire logic memWrite,
   input wire logic [7:0] memAddr,
   input wire logic [7:0] memData
);
   logic [7:0] pmem [256];
   logic [7:0] dmem [256];
   ////////////////////////////////////////
   // one-cycle read; the last byte stands one cycle after release, then turns to junk
   always_ff @(posedge sys_clk) begin
      if (progRead) begin
         progData <= pmem[progAddr];
      end else begin
         progData <= ~progData;
      end
   end
   // data memory takes the defuzzified byte
   always_ff @(posedge sys_clk) begin
      if (memWrite) begin
         dmem[memAddr] <= memData;
      end
   end
endmodule
`default_nettype wire

// ==== fzd_pkg.sv ====
// types of the fuzzy inference datapath
package fzd_pkg;
   typedef enum logic [3:0] {
      FZD_OP_NONE, FZD_OP_PUSH_GRADE, FZD_OP_PUSH_NEGATED_GRADE, FZD_OP_PUSH_LAST,
      FZD_OP_PUSH_HELD_RESULT, FZD_OP_AND, FZD_OP_OR, FZD_OP_STORE, FZD_OP_CON, FZD_OP_OUT
   } fzd_op_t;
endpackage
